// ==== wdtw_pkg.sv ====
// package for the windowed watchdog: register map, fields, timing counts
// assumes a 100 MHz system clock and a nominal 32 kHz low-power oscillator
package wdtw_pkg;
   // register offsets (word index on the plain register port)
   localparam logic [3:0] WDTW_ADDR_CFG = 4'h0; // watchdog_config_word
   localparam logic [3:0] WDTW_ADDR_RESET_CONTROL_REG = 4'h1; // reset_control_reg
   localparam logic [3:0] WDTW_ADDR_STAT = 4'h2; // live counter state
   localparam int WDTW_AW = 4;
   localparam int WDTW_DW = 16;
   // configuration word fields
   localparam int WDTW_CFG_POST_LSB = 0;
   localparam int WDTW_CFG_PRE_BIT = 4;
   localparam int WDTW_CFG_FUSE_BIT = 5;
   localparam int WDTW_CFG_WIN_BIT = 6;
   localparam logic [15:0] WDTW_CFG_RST = 16'h007F;
   // reset control fields
   localparam int WDTW_RC_IDLE_BIT = 2;
   localparam int WDTW_RC_SLEEP_BIT = 3;
   localparam int WDTW_RC_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
   localparam int WDTW_RC_SWEN_BIT = 5;
   // oscillator and prescale timing
   localparam int WDTW_CLK_HZ = 100_000_000;
   localparam int WDTW_LOW_POWER_RC_OSC_HZ = 32_000;
   localparam int WDTW_LOW_POWER_RC_OSC_DIV = WDTW_CLK_HZ / WDTW_LOW_POWER_RC_OSC_HZ / 2;
   localparam int WDTW_PRE_SHORT = 32;
   localparam int WDTW_PRE_LONG = 128;
   localparam int WDTW_POST_W = 16;
   // core power state
   typedef enum logic [1:0] {WDTW_RUN, WDTW_SLEEP, WDTW_IDLE} wdtw_pwr_t;
endpackage : wdtw_pkg

// ==== wdtw_low_power_rc_osc.sv ====
// low-power oscillator model: divides the system clock to a 32 kHz tick
// assumes one clock domain; the tick is a one-cycle enable pulse
`timescale 1ns/1ns
module wdtw_low_power_rc_osc
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_osc_on,
   // tick out
   output logic o_tick
);
   import wdtw_pkg::*;
   logic [15:0] cnt_r, cnt_nxt;
   logic tick_nxt;
   // count one full oscillator period while forced on
   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (!i_osc_on) begin
         cnt_nxt = 16'h0000;
      end else if (cnt_r == 16'(WDTW_CLK_HZ / WDTW_LOW_POWER_RC_OSC_HZ - 1)) begin
         cnt_nxt = 16'h0000;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_r <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         o_tick <= tick_nxt;
      end
   end
endmodule : wdtw_low_power_rc_osc

// ==== wdtw_scaler.sv ====
// prescaler plus postscaler chain producing expiry and window-open flags
// assumes i_tick is a one-cycle pulse at the oscillator rate
`timescale 1ns/1ns
module wdtw_scaler
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_tick,
   input wire logic i_run,
   input wire logic i_clear,
   input wire logic i_prescale_ratio_select,
   input wire logic [3:0] i_postscale_ratio_select,
   // status
   output logic o_expire,
   output logic o_window_open,
   output logic [15:0] o_post_cnt
);
   import wdtw_pkg::*;
   logic [6:0] pre_r, pre_nxt;
   logic [15:0] post_r, post_nxt;
   logic expire_nxt;
   logic [6:0] pre_last;
   logic [15:0] post_last;
   // prescale 32 or 128; postscale 2^code
   assign pre_last = i_prescale_ratio_select ? 7'(WDTW_PRE_LONG - 1)
                                             : 7'(WDTW_PRE_SHORT - 1);
   assign post_last = 16'((17'h00001 << i_postscale_ratio_select) - 17'h1);
   // advance the chain on each oscillator tick
   always_comb begin
      pre_nxt = pre_r;
      post_nxt = post_r;
      expire_nxt = 1'b0;
      if (i_clear || !i_run) begin
         pre_nxt = 7'h00;
         post_nxt = 16'h0000;
      end else if (i_tick) begin
         if (pre_r >= pre_last) begin
            pre_nxt = 7'h00;
            if (post_r >= post_last) begin
               post_nxt = 16'h0000;
               expire_nxt = 1'b1;
            end else begin
               post_nxt = post_r + 16'h0001;
            end
         end else begin
            pre_nxt = pre_r + 7'h01;
         end
      end
   end
   // window opens in the last quarter of the period for postscale codes 2 up; codes 0 and 1 also need pre_r >= 3 * pre_last[6:2]
   assign o_window_open = ({post_r, 2'b00} >= {2'b00, post_last} * 18'd3)
                          && (post_last >= 16'h0003 || pre_r >= {2'b00, pre_last[6:2]} * 7'd3);
   assign o_post_cnt = post_r;
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pre_r <= 7'h00;
         post_r <= 16'h0000;
         o_expire <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         post_r <= post_nxt;
         o_expire <= expire_nxt;
      end
   end
endmodule : wdtw_scaler

// ==== wdtw_top.sv ====
// What this block does
// - watchdog runs on low-power oscillator, forcing it on
// - prescaler divides 32 kHz by 32 or 128
// - base period 1 ms or 4 ms
// - postscaler sixteen ratios from four-bit field
// - any device reset clears all counters
// - completed clock switch clears counters
// - power-save instruction clears the counts
// - leaving sleep or idle clears counters
// - clear instruction clears all counters
// - keeps counting in sleep and idle
// - timeout in power save wakes, no reset
// - fuse enable forces run, soft bit ignored
// - without fuse, soft enable bit gates running
// - soft enable bit cleared by every reset
// - early clear in window mode resets device
// - timeout sets sticky flag, software clears
// - prescale bit one means divide by 128
// - window-off bit one means normal mode
// - postscale code maps to power-of-two ratio
//
// top of the windowed watchdog with its register port
// assumes core events arrive as one-cycle pulses on i_ref_clk
`timescale 1ns/1ns
module wdtw_top
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [wdtw_pkg::WDTW_AW-1:0] i_addr,
   input wire logic [wdtw_pkg::WDTW_DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [wdtw_pkg::WDTW_DW-1:0] o_rdata,
   // core events
   input wire logic i_watchdog_clear_instr,
   input wire logic i_power_save_instr,
   input wire logic i_power_save_idle,
   input wire logic i_osc_switch_done,
   input wire logic i_core_wake,
   // outputs to the system
   output logic o_wdt_reset_req,
   output logic o_wake_req,
   output logic o_low_power_rc_osc_on
);
   import wdtw_pkg::*;

   logic [15:0] cfg_r, cfg_nxt;
   logic swen_r, swen_nxt;
   logic watchdog_timeout_flag_r, watchdog_timeout_flag_nxt;
   logic sleep_f_r, sleep_f_nxt;
   logic idle_f_r, idle_f_nxt;
   wdtw_pwr_t pwr_r, pwr_nxt;
   logic [15:0] rdata_nxt;
   logic rst_req_nxt, wake_nxt, osc_nxt;
   logic enabled, clear, tick, expire, win_open;
   logic [15:0] post_cnt;
   logic early_clear, wake_evt;
   logic win_mode;

   // enable: fuse overrides, else software bit
   assign enabled = cfg_r[WDTW_CFG_FUSE_BIT] | swen_r;
   assign win_mode = ~cfg_r[WDTW_CFG_WIN_BIT];
   // window check on a clear during normal execution
   assign early_clear = enabled && win_mode && (pwr_r == WDTW_RUN)
                        && i_watchdog_clear_instr && !win_open;
   assign wake_evt = (pwr_r != WDTW_RUN) && (i_core_wake || expire);
   // every counter-clearing event
   assign clear = i_osc_switch_done
                  || (i_power_save_instr && pwr_r == WDTW_RUN)
                  || wake_evt
                  || (i_watchdog_clear_instr && pwr_r == WDTW_RUN);

   wdtw_low_power_rc_osc u_low_power_rc_osc (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_osc_on(o_low_power_rc_osc_on),
      .o_tick(tick)
   );

   wdtw_scaler u_scaler (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_tick(tick),
      .i_run(enabled),
      .i_clear(clear),
      .i_prescale_ratio_select(cfg_r[WDTW_CFG_PRE_BIT]),
      .i_postscale_ratio_select(cfg_r[WDTW_CFG_POST_LSB +: 4]),
      .o_expire(expire),
      .o_window_open(win_open),
      .o_post_cnt(post_cnt)
   );

   // register writes, power state and flags
   always_comb begin
      cfg_nxt = cfg_r;
      swen_nxt = swen_r;
      watchdog_timeout_flag_nxt = watchdog_timeout_flag_r;
      sleep_f_nxt = sleep_f_r;
      idle_f_nxt = idle_f_r;
      pwr_nxt = pwr_r;
      rst_req_nxt = 1'b0;
      wake_nxt = 1'b0;
      if (i_wr && i_addr == WDTW_ADDR_CFG) begin
         cfg_nxt = i_wdata;
      end else if (i_wr && i_addr == WDTW_ADDR_RESET_CONTROL_REG) begin
         swen_nxt = i_wdata[WDTW_RC_SWEN_BIT];
         watchdog_timeout_flag_nxt = i_wdata[WDTW_RC_WATCHDOG_TIMEOUT_FLAG_BIT];
         sleep_f_nxt = i_wdata[WDTW_RC_SLEEP_BIT];
         idle_f_nxt = i_wdata[WDTW_RC_IDLE_BIT];
      end
      case (pwr_r)
         WDTW_RUN: begin
            if (i_power_save_instr) begin
               pwr_nxt = i_power_save_idle ? WDTW_IDLE : WDTW_SLEEP;
               if (i_power_save_idle) begin
                  idle_f_nxt = 1'b1;
               end else begin
                  sleep_f_nxt = 1'b1;
               end
            end
         end
         default: begin
            if (wake_evt) begin
               pwr_nxt = WDTW_RUN;
               wake_nxt = expire;
            end
         end
      endcase
      // set wins over a software clear
      if (expire && enabled) begin
         watchdog_timeout_flag_nxt = 1'b1;
         if (pwr_r == WDTW_RUN) begin
            rst_req_nxt = 1'b1;
         end
      end
      if (early_clear) begin
         watchdog_timeout_flag_nxt = 1'b1;
         rst_req_nxt = 1'b1;
      end
      osc_nxt = cfg_nxt[WDTW_CFG_FUSE_BIT] | swen_nxt;
   end

   // read data, one cycle after the strobe
   always_comb begin
      rdata_nxt = 16'h0000;
      if (i_rd) begin
         if (i_addr == WDTW_ADDR_CFG) begin
            rdata_nxt = cfg_r;
         end else if (i_addr == WDTW_ADDR_RESET_CONTROL_REG) begin
            rdata_nxt[WDTW_RC_SWEN_BIT] = swen_r;
            rdata_nxt[WDTW_RC_WATCHDOG_TIMEOUT_FLAG_BIT] = watchdog_timeout_flag_r;
            rdata_nxt[WDTW_RC_SLEEP_BIT] = sleep_f_r;
            rdata_nxt[WDTW_RC_IDLE_BIT] = idle_f_r;
         end else if (i_addr == WDTW_ADDR_STAT) begin
            rdata_nxt = post_cnt;
         end
      end
   end

   // register stage; reset clears soft enable and state
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cfg_r <= WDTW_CFG_RST;
         swen_r <= 1'b0;
         watchdog_timeout_flag_r <= 1'b0;
         sleep_f_r <= 1'b0;
         idle_f_r <= 1'b0;
         pwr_r <= WDTW_RUN;
         o_rdata <= 16'h0000;
         o_wdt_reset_req <= 1'b0;
         o_wake_req <= 1'b0;
         o_low_power_rc_osc_on <= 1'b1;
      end else begin
         cfg_r <= cfg_nxt;
         swen_r <= swen_nxt;
         watchdog_timeout_flag_r <= watchdog_timeout_flag_nxt;
         sleep_f_r <= sleep_f_nxt;
         idle_f_r <= idle_f_nxt;
         pwr_r <= pwr_nxt;
         o_rdata <= rdata_nxt;
         o_wdt_reset_req <= rst_req_nxt;
         o_wake_req <= wake_nxt;
         o_low_power_rc_osc_on <= osc_nxt;
      end
   end

   // checks
   sequence s_sleep_expire;
      (pwr_r != WDTW_RUN) && expire && enabled;
   endsequence
   chk_sleep_wakes: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_sleep_expire |=> o_wake_req && !o_wdt_reset_req)
      else $error("power-save timeout did not wake");
   chk_run_reset: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (pwr_r == WDTW_RUN) && expire && enabled |=> o_wdt_reset_req && watchdog_timeout_flag_r)
      else $error("run timeout gave no reset");
   chk_early_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      early_clear |=> o_wdt_reset_req)
      else $error("early clear gave no reset");
   chk_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      watchdog_timeout_flag_r && !(i_wr && i_addr == WDTW_ADDR_RESET_CONTROL_REG) |=> watchdog_timeout_flag_r)
      else $error("timeout flag dropped by itself");
   chk_fuse_osc: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      cfg_r[WDTW_CFG_FUSE_BIT] |-> o_low_power_rc_osc_on)
      else $error("oscillator off with fuse enable");
   chk_clear_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      clear |=> post_cnt == 16'h0000)
      else $error("clear left counts");
   chk_soft_off: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !enabled |=> post_cnt == 16'h0000 && !expire)
      else $error("disabled watchdog counted");
   chk_read_cfg: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == WDTW_ADDR_CFG |=> o_rdata == $past(cfg_r))
      else $error("config readback wrong");

   // clear instruction inside an open window, no expiry beside it
   sequence s_legal_clear;
      (pwr_r == WDTW_RUN) && i_watchdog_clear_instr && enabled && win_mode
         && win_open && !expire;
   endsequence
   // clear instruction in normal mode, no expiry beside it
   sequence s_plain_clear;
      (pwr_r == WDTW_RUN) && i_watchdog_clear_instr && !win_mode && !expire;
   endsequence
   // power-save entry from normal execution
   sequence s_psv_entry;
      (pwr_r == WDTW_RUN) && i_power_save_instr;
   endsequence

   // a clear inside the window never resets
   chk_late_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_legal_clear |=> !o_wdt_reset_req)
      else $error("window clear gave reset");
   // normal mode accepts a clear at any time
   chk_plain_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_plain_clear |=> !o_wdt_reset_req)
      else $error("normal clear gave reset");
   // power-save entry clears the counts and leaves run
   chk_psv_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_psv_entry |=> post_cnt == 16'h0000 && pwr_r != WDTW_RUN)
      else $error("power-save entry kept counts");
   // sleep entry records its status flag
   chk_sleep_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (pwr_r == WDTW_RUN) && i_power_save_instr && !i_power_save_idle
      |=> sleep_f_r && pwr_r == WDTW_SLEEP)
      else $error("sleep entry not recorded");
   // idle entry records its status flag
   chk_idle_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (pwr_r == WDTW_RUN) && i_power_save_instr && i_power_save_idle
      |=> idle_f_r && pwr_r == WDTW_IDLE)
      else $error("idle entry not recorded");
   // leaving power save clears the counts
   chk_wake_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      wake_evt |=> post_cnt == 16'h0000 && pwr_r == WDTW_RUN)
      else $error("wake kept counts");
   // completed clock switch clears the counts
   chk_switch_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_osc_switch_done |=> post_cnt == 16'h0000)
      else $error("clock switch kept counts");
   // no reset request while the core sleeps
   chk_asleep_quiet: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      pwr_r != WDTW_RUN |=> !o_wdt_reset_req)
      else $error("reset requested in power save");
   // wake request is a single-cycle pulse
   chk_wake_once: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_wake_req |=> !o_wake_req)
      else $error("wake request too long");
   // a power-save time-out also sets the flag
   chk_sleep_flagset: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_sleep_expire |=> watchdog_timeout_flag_r)
      else $error("power-save timeout left flag clear");
   // oscillator stops whenever both enables are off
   chk_soft_osc: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !cfg_r[WDTW_CFG_FUSE_BIT] && !swen_r |-> !o_low_power_rc_osc_on)
      else $error("oscillator on while disabled");
   // configuration writes land whole
   chk_cfg_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_wr && i_addr == WDTW_ADDR_CFG |=> cfg_r == $past(i_wdata))
      else $error("config write lost");
   // soft enable follows its control write
   chk_swen_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_wr && i_addr == WDTW_ADDR_RESET_CONTROL_REG
      |=> swen_r == $past(i_wdata[WDTW_RC_SWEN_BIT]))
      else $error("soft enable write lost");
   // software clear of the flag works when no event competes
   chk_watchdog_timeout_flag_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_wr && i_addr == WDTW_ADDR_RESET_CONTROL_REG && !i_wdata[WDTW_RC_WATCHDOG_TIMEOUT_FLAG_BIT]
      && !(expire && enabled) && !early_clear |=> !watchdog_timeout_flag_r)
      else $error("timeout flag not cleared");
   // control readback shows the timeout flag
   chk_read_reset_control_reg: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == WDTW_ADDR_RESET_CONTROL_REG
      |=> o_rdata[WDTW_RC_WATCHDOG_TIMEOUT_FLAG_BIT] == $past(watchdog_timeout_flag_r))
      else $error("control readback wrong");
   // status readback shows the postscaler count
   chk_read_stat: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == WDTW_ADDR_STAT |=> o_rdata == $past(post_cnt))
      else $error("status readback wrong");
   // read data stand only after a read strobe
   chk_read_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !i_rd |=> o_rdata == 16'h0000)
      else $error("read data without strobe");
endmodule : wdtw_top

// ==== wdtw_top_test.sv ====
// self-checking bench for the windowed watchdog top
// assumes the 100 MHz clock and a register port with one-cycle strobes
`timescale 1ns/1ns
module wdtw_top_test;
   import wdtw_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [WDTW_AW-1:0] i_addr = '0;
   logic [WDTW_DW-1:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [WDTW_DW-1:0] o_rdata;
   logic i_clr = 1'b0;
   logic i_psv = 1'b0;
   logic i_psv_idle = 1'b0;
   logic i_osw = 1'b0;
   logic i_wake = 1'b0;
   logic o_wdt_reset_req;
   logic o_wake_req;
   logic o_low_power_rc_osc_on;
   int n_mismatch = 0;
   int check_count = 0;
   logic [15:0] rd_v;
   int n;

   // device under test
   wdtw_top u_wdtw_top (
      .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_watchdog_clear_instr(i_clr), .i_power_save_instr(i_psv),
      .i_power_save_idle(i_psv_idle), .i_osc_switch_done(i_osw),
      .i_core_wake(i_wake), .o_wdt_reset_req(o_wdt_reset_req),
      .o_wake_req(o_wake_req), .o_low_power_rc_osc_on(o_low_power_rc_osc_on)
   );

   // 100 MHz clock
   always #5 i_ref_clk = ~i_ref_clk;

   // verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // compare a 16-bit value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // register write, one strobe cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr

   // register read, data sampled in the following cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   // one-cycle event pulse: 0 clear, 1 power save, 2 switch, 3 wake
   // returns just after the edge at which the design took the event
   task automatic pulse(input int which);
      @(posedge i_ref_clk);
      case (which)
         0: i_clr <= 1'b1;
         1: i_psv <= 1'b1;
         2: i_osw <= 1'b1;
         default: i_wake <= 1'b1;
      endcase
      @(posedge i_ref_clk);
      {i_clr, i_psv, i_osw, i_wake} <= 4'h0;
      #1;
   endtask : pulse

   // bounded wait on reset request (0) or wake request (1)
   task automatic wait_out(input int which, input int lim, output int cnt);
      for (cnt = 0; cnt < lim; cnt++) begin
         @(posedge i_ref_clk);
         #1;
         if ((which == 0 && o_wdt_reset_req === 1'b1) ||
             (which == 1 && o_wake_req === 1'b1)) return;
         if (which == 1 && o_wdt_reset_req !== 1'b0) begin
            chk(16'h1, 16'h0, "reset while asleep");
         end
      end
      chk(16'h1, 16'h0, "wait limit");
      complete_run();
   endtask : wait_out

   // reset values, unmapped index, oscillator forced on
   task automatic t_reset;
      rd(WDTW_ADDR_CFG, rd_v); chk(rd_v, WDTW_CFG_RST, "cfg");
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0000, "reset_control_reg");
      rd(4'hF, rd_v); chk(rd_v, 16'h0000, "unmapped");
      chk({15'h0, o_low_power_rc_osc_on}, 16'h1, "osc on");
      $display("test reset done");
   endtask : t_reset

   // soft enable gates the oscillator, cleared by a second reset
   task automatic t_soft;
      wr(WDTW_ADDR_CFG, 16'h0040);
      wr(4'hE, 16'hFFFF);
      repeat (2) @(posedge i_ref_clk);
      chk({15'h0, o_low_power_rc_osc_on}, 16'h0, "osc off");
      rd(WDTW_ADDR_CFG, rd_v); chk(rd_v, 16'h0040, "unmapped wr");
      wr(WDTW_ADDR_RESET_CONTROL_REG, 16'h0020);
      repeat (2) @(posedge i_ref_clk);
      chk({15'h0, o_low_power_rc_osc_on}, 16'h1, "osc soft");
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0020, "swen");
      @(posedge i_ref_clk) i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0000, "swen rst");
      rd(WDTW_ADDR_CFG, rd_v); chk(rd_v, WDTW_CFG_RST, "cfg rst");
      $display("test soft enable done");
   endtask : t_soft

   // early clear in window mode requests reset, flag sticky
   task automatic t_window;
      wr(WDTW_ADDR_CFG, 16'h0020);
      rd(WDTW_ADDR_CFG, rd_v); chk(rd_v, 16'h0020, "cfg win");
      pulse(0);
      chk({15'h0, o_wdt_reset_req}, 16'h1, "early clear");
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0010, "flag");
      wr(WDTW_ADDR_RESET_CONTROL_REG, 16'h0000);
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0000, "flag clr");
      // about 25 ticks later pre_r has passed 21 of 32 ticks and the window is open
      repeat (78000) @(posedge i_ref_clk);
      pulse(0);
      chk({15'h0, o_wdt_reset_req}, 16'h0, "late clear");
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0000, "no flag");
      $display("test window done");
   endtask : t_window

   // sleep time-out wakes the core after 32 ticks of divide-by-32
   task automatic t_sleep;
      wr(WDTW_ADDR_CFG, 16'h0060);
      pulse(2);
      pulse(1);
      wait_out(1, 110000, n);
      chk({15'h0, 1'(n >= 31 * 3125)}, 16'h1, "period min");
      chk({15'h0, 1'(n <= 32 * 3125 + 10)}, 16'h1, "period max");
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v);
      chk(rd_v & 16'h001C, 16'h0018, "sleep flags");
      wr(WDTW_ADDR_RESET_CONTROL_REG, 16'h0000);
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0000, "reset_control_reg clr");
      $display("test sleep done");
   endtask : t_sleep

   // idle entry, other wake source: no watchdog wake, idle flag set
   task automatic t_idle;
      i_psv_idle <= 1'b1;
      pulse(1);
      i_psv_idle <= 1'b0;
      pulse(3);
      chk({15'h0, o_wake_req}, 16'h0, "core wake");
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0004, "idle flag");
      rd(WDTW_ADDR_STAT, rd_v); chk(rd_v, 16'h0000, "count clr");
      wr(WDTW_ADDR_RESET_CONTROL_REG, 16'h0000);
      rd(WDTW_ADDR_RESET_CONTROL_REG, rd_v); chk(rd_v, 16'h0000, "idle clr");
      $display("test idle done");
   endtask : t_idle

   // main sequence
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_soft();
      t_window();
      t_sleep();
      t_idle();
      complete_run();
   end
endmodule : wdtw_top_test
